// [pkg/ddsc_pkg.sv]
// Constants and carrier types of the dual DAC serial store control block
// ============================================================================
// How it works
// - Frame begins at first high bit while selected
// - Address and data travel LSB first
// - Serial input sampled on serial clock rise
// - Deselect restores both registers, output floats
// - Output driver enabled while chip selected and not busy
// - Short deselect glitches are filtered out
// - Output bit changes on serial clock rise
// - Power-up restores registers without serial clock
// - Store drives ready/busy low until done
// - While busy, input ignored, output silent
// - Low supply keeps ready/busy high, no store
// - Held value shifts out after address bits
// - Frame is start, two address, eight data
// - Output updates on the serial clock rise of the last data bit
// - Ready for next frame two clocks later
// - Every write shifts out the held value
// - Temporary updates unlimited while selected
// - Store request honoured from the address bits until two clocks after the data; unstored data kept until deselect
// - Address 0,1 is first DAC; 1,1 second
package ddsc_pkg;

	// ========================================================================
	// Widths and codes
	localparam int          DATA_W       = 8;
	localparam logic [1:0]  SEL_FIRST    = 2'h2;   // bit0=0, bit1=1
	localparam logic [1:0]  SEL_SECOND   = 2'h3;   // bit0=1, bit1=1
	localparam logic [7:0]  EEPROM_RST   = 8'h80;  // Blank cell content

	// ========================================================================
	// Timing
	localparam int CLK_NS        = 10;
	localparam int CS_FILT_NS    = 90;
	localparam int CS_FILT_CYC   = (CS_FILT_NS + CLK_NS - 1) / CLK_NS;
	localparam int BUSY_MS       = 5;
	localparam int BUSY_CYC      = BUSY_MS * 1000000 / CLK_NS;
	localparam int HOLD_CLKS     = 2;  // Link clocks a value waits for store

	// ========================================================================
	// Frame states
	typedef enum logic [2:0] {
		DDSC_IDLE,
		DDSC_ADDR,
		DDSC_DATA,
		DDSC_GAP,
		DDSC_BUSY
	} ddsc_state_e;

	// Link pins as seen by the core
	typedef struct packed {
		logic sclk;
		logic cs;
		logic sdi;
		logic store;
	} ddsc_pins_s;

	// Per-DAC register and nonvolatile copy
	typedef struct packed {
		logic [7:0] live;
		logic [7:0] nv;
	} ddsc_dac_s;

endpackage : ddsc_pkg

// [sim/ddsc_host.sv]
// Host model driving the three-wire link and the store request
`timescale 1ns/1ps
module ddsc_host (
	input  wire logic clk,
	input  wire logic serial_out,
	input  wire logic store_ready_n_busy,
	output logic      serial_clk,
	output logic      chip_sel,
	output logic      serial_in,
	output logic      store_request
);
	// Link clock stands still low between frames
	initial
	begin
		serial_clk = 1'b0;
		chip_sel = 1'b1;
		serial_in = 1'b0;
		store_request = 1'b0;
	end
	// ==========
	// One 160 ns link period; read data taken just before the rise
	task automatic tick(input logic b, output logic q);
		serial_in = b;
		repeat (8) @(negedge clk);
		q = serial_out;
		serial_clk = 1'b1;
		repeat (8) @(negedge clk);
		serial_clk = 1'b0;
	endtask : tick
	// Start, address, data, two gap clocks, then clocks kept running
	task automatic frame(input logic [1:0] sel, input logic [7:0] d,
		input logic st, output logic [7:0] old, output logic bsy);
		logic [12:0] bits;
		logic        q;
		bits = {2'b00, d, sel, 1'b1};
		bsy = 1'b0;
		for (int i = 0; i < 13; i++)
		begin
			if (i == 1)
				store_request = st;
			tick(bits[i], q);
			if (i >= 3 && i <= 10)
				old[i-3] = q;
		end
		store_request = 1'b0;
		repeat (6)
		begin
			tick(1'b0, q);
			bsy |= !store_ready_n_busy;
		end
	endtask : frame
	// Deselect for n clk cycles, then settle before the next frame
	task automatic desel(input int n);
		chip_sel = 1'b0;
		repeat (n) @(negedge clk);
		chip_sel = 1'b1;
		repeat (20) @(negedge clk);
	endtask : desel
endmodule : ddsc_host

// [sim/ddsc_top_assertions.sv]
// Port-level checker of the dual DAC serial store control
`timescale 1ns/1ps
module ddsc_top_checker
	import ddsc_pkg::*;
#(
	parameter int BUSY_CYCLES = 50
) (
	input wire logic       clk,
	input wire logic       sys_rst,
	input wire logic       serial_clk,
	input wire logic       chip_sel,
	input wire logic       serial_in,
	input wire logic       store_request,
	input wire logic       supply_ok,
	input wire logic       serial_out,
	input wire logic       serial_out_oe,
	input wire logic       store_ready_n_busy,
	input wire logic [7:0] first_dac_output,
	input wire logic [7:0] second_dac_output
);
	// Slack allows for the pin synchronisers ahead of the busy timer
	localparam int BMAX = BUSY_CYCLES + 4;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// ==========
	// Checks
	reset_state_a: assert property (disable iff (1'b0) $fell(sys_rst) |->
		store_ready_n_busy && !serial_out_oe && first_dac_output == EEPROM_RST
		&& second_dac_output == EEPROM_RST) else $error("bad reset state");
	busy_quiet_a: assert property (!store_ready_n_busy ##1 !store_ready_n_busy
		|-> !serial_out_oe) else $error("output driven while busy");
	oe_needs_cs_a: assert property ($rose(serial_out_oe) |->
		$past(chip_sel, 3) && store_ready_n_busy) else $error("oe without cs");
	oe_drop_a: assert property ($fell(chip_sel) ##1 !chip_sel[*8] |->
		##8 !serial_out_oe) else $error("oe stays on after deselect");
	busy_span_a: assert property ($fell(store_ready_n_busy) |->
		!store_ready_n_busy[*8]) else $error("busy too short");
	busy_bound_a: assert property ($fell(store_ready_n_busy) |->
		##[1:BMAX] store_ready_n_busy) else $error("busy never ends");
	low_supply_a: assert property ($fell(store_ready_n_busy) |->
		$past(supply_ok)) else $error("busy shown on low supply");
	restore_cs_a: assert property ($changed(first_dac_output) &&
		$changed(second_dac_output) |-> !$past(chip_sel, 9))
		else $error("both DACs moved while selected");
	busy_still_a: assert property (!store_ready_n_busy &&
		!$past(store_ready_n_busy) |-> $stable(first_dac_output) &&
		$stable(second_dac_output)) else $error("DAC moved while busy");
	cover property ($fell(store_ready_n_busy));
	cover property ($fell(serial_out_oe));
	cover property ($changed(second_dac_output));
endmodule : ddsc_top_checker

bind ddsc_top ddsc_top_checker #(.BUSY_CYCLES(BUSY_CYCLES)) CHK (.clk,
	.sys_rst, .serial_clk, .chip_sel, .serial_in, .store_request,
	.supply_ok, .serial_out, .serial_out_oe, .store_ready_n_busy,
	.first_dac_output, .second_dac_output);

// [sim/ddsc_top_tb.sv]
// Self-checking bench of the dual DAC serial store control
`timescale 1ns/1ps
module ddsc_top_tb;
	import ddsc_pkg::*;
	logic       clk = 1'b0;
	logic       sys_rst = 1'b1;
	logic       supply_ok = 1'b1;
	logic       sclk, cs, sdi, st, sdo, oe, rdy;
	logic [7:0] dac1, dac2, r;
	logic [7:0] t1 = EEPROM_RST, t2 = EEPROM_RST;
	logic [7:0] nv1 = EEPROM_RST, nv2 = EEPROM_RST;
	int         fail_count = 0, num_checks = 0;
	int         seed = 32'h8f9d0138;
	// Clock and pieces
	always #5 clk = ~clk;
	ddsc_top #(.BUSY_CYCLES(50)) DUT (.clk(clk), .sys_rst(sys_rst),
		.serial_clk(sclk), .chip_sel(cs), .serial_in(sdi),
		.store_request(st), .supply_ok(supply_ok), .serial_out(sdo),
		.serial_out_oe(oe), .store_ready_n_busy(rdy),
		.first_dac_output(dac1), .second_dac_output(dac2));
	ddsc_host HOST (.clk(clk), .serial_out(sdo), .store_ready_n_busy(rdy),
		.serial_clk(sclk), .chip_sel(cs), .serial_in(sdi),
		.store_request(st));
	// ==========
	// Expectations and compares
	function automatic logic exp_busy(input logic [1:0] a, input logic s);
		return s && supply_ok && (a == SEL_FIRST || a == SEL_SECOND);
	endfunction : exp_busy
	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check8
	task automatic wr(input logic [1:0] a, input logic [7:0] d,
		input logic s);
		logic       b;
		logic [7:0] o;
		HOST.frame(a, d, s, o, b);
		if (a == SEL_FIRST)
		begin
			check8(o, t1);
			t1 = d;
			nv1 = exp_busy(a, s) ? d : nv1;
		end
		if (a == SEL_SECOND)
		begin
			check8(o, t2);
			t2 = d;
			nv2 = exp_busy(a, s) ? d : nv2;
		end
		check8(dac1, t1);
		check8(dac2, t2);
		check8({7'h0, b}, {7'h0, exp_busy(a, s)});
	endtask : wr
	task automatic rs(input int n);
		HOST.desel(n);
		if (n > 9)
		begin
			t1 = nv1;
			t2 = nv2;
		end
		check8(dac1, t1);
		check8(dac2, t2);
	endtask : rs
	task automatic stop_test;
		$display("checks=%0d fails=%0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : stop_test
	// Main sequence: temporary writes, stores, bad codes, deselects
	initial
	begin
		repeat (6) @(negedge clk);
		sys_rst = 1'b0;
		repeat (20) @(negedge clk);
		check8(dac1, EEPROM_RST);
		check8(dac2, EEPROM_RST);
		repeat (6)
		begin
			r = $random(seed);
			wr({1'b1, r[0]}, $random(seed), 1'b0);
		end
		wr(SEL_FIRST, 8'h3c, 1'b1);
		wr(SEL_SECOND, 8'h00, 1'b0);
		rs(30);
		wr(2'b00, 8'hff, 1'b1);
		wr(2'b01, 8'hc3, 1'b0);
		supply_ok = 1'b0;
		wr(SEL_SECOND, 8'h11, 1'b1);
		supply_ok = 1'b1;
		rs(5);
		wr(SEL_SECOND, 8'hff, 1'b1);
		wr(SEL_FIRST, 8'h5a, 1'b0);
		wr(SEL_SECOND, 8'ha5, 1'b0);
		rs(30);
		stop_test();
	end
	// Watchdog well beyond the expected run of about 44 us
	initial
	begin
		#300us;
		fail_count++;
		stop_test();
	end
endmodule : ddsc_top_tb

// [src/ddsc_sync.sv]
// Two-stage synchroniser with glitch filter for one pin
`timescale 1ns/1ps
module ddsc_sync #(
	parameter int FILT = 1,
	parameter logic INIT = 1'b0
) (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic pin,
	output logic      level
);
	import ddsc_pkg::*;

	typedef struct packed {
		logic       s1;
		logic       s2;
		logic [7:0] cnt;
		logic       level;
	} ddsc_sync_s;

	ddsc_sync_s r;
	ddsc_sync_s next_r;

	// ========================================================================
	// Filter: level follows only after FILT stable synced samples
	always_comb
	begin
		next_r    = r;
		next_r.s1 = pin;
		next_r.s2 = r.s1;
		if (r.s2 == r.level)
			next_r.cnt = 8'h00;
		else if (r.cnt >= 8'(FILT - 1))
		begin
			next_r.level = r.s2;
			next_r.cnt   = 8'h00;
		end
		else
			next_r.cnt = r.cnt + 8'h01;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			r <= '{s1: INIT, s2: INIT, cnt: 8'h00, level: INIT};
		else
			r <= next_r;
	end

	assign level = r.level;

endmodule : ddsc_sync

// [src/ddsc_top.sv]
// Serial control and store sequencing of a dual 8-bit nonvolatile DAC
`timescale 1ns/1ps
module ddsc_top #(
	parameter int BUSY_CYCLES = ddsc_pkg::BUSY_CYC
) (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        serial_clk,
	input  wire logic        chip_sel,
	input  wire logic        serial_in,
	input  wire logic        store_request,
	input  wire logic        supply_ok,
	output logic             serial_out,
	output logic             serial_out_oe,
	output logic             store_ready_n_busy,
	output logic [7:0]       first_dac_output,
	output logic [7:0]       second_dac_output
);
	import ddsc_pkg::*;

	// ========================================================================
	// Pin synchronisers; chip select also gets the glitch filter
	ddsc_pins_s pins;

	ddsc_sync #(.FILT(1), .INIT(1'b0)) u_sclk
	(
		.clk     (clk),
		.sys_rst (sys_rst),
		.pin     (serial_clk),
		.level   (pins.sclk)
	);

	ddsc_sync #(.FILT(CS_FILT_CYC), .INIT(1'b0)) u_cs
	(
		.clk     (clk),
		.sys_rst (sys_rst),
		.pin     (chip_sel),
		.level   (pins.cs)
	);

	ddsc_sync #(.FILT(1), .INIT(1'b0)) u_sdi
	(
		.clk     (clk),
		.sys_rst (sys_rst),
		.pin     (serial_in),
		.level   (pins.sdi)
	);

	ddsc_sync #(.FILT(1), .INIT(1'b0)) u_store
	(
		.clk     (clk),
		.sys_rst (sys_rst),
		.pin     (store_request),
		.level   (pins.store)
	);

	// ========================================================================
	// Whole module state
	typedef struct packed {
		ddsc_state_e st;
		logic        sclk_d;
		logic [3:0]  bitn;
		logic [1:0]  sel;
		logic [7:0]  shin;
		logic [7:0]  shout;
		logic [1:0]  gap;
		logic        store_seen;
		logic        is_second;
		logic [31:0] busy_cnt;
		ddsc_dac_s   d0;
		ddsc_dac_s   d1;
		logic        sdo;
		logic        oe;
		logic        rdy;
		logic [7:0]  out0;
		logic [7:0]  out1;
	} ddsc_state_s;

	ddsc_state_s r;
	ddsc_state_s next_r;

	logic sclk_rise;
	logic sel_ok;

	assign sclk_rise = pins.sclk && !r.sclk_d;
	assign sel_ok    = (r.sel == SEL_FIRST) || (r.sel == SEL_SECOND);

	// ========================================================================
	// Frame sequencer, steps timed by sampled serial clock rises except the busy count on clk
	always_comb
	begin
		next_r        = r;
		next_r.sclk_d = pins.sclk;

		unique case (r.st)
			DDSC_IDLE:
			begin
				// Wait for first high bit while selected
				if (pins.cs && sclk_rise && pins.sdi)
				begin
					next_r.st         = DDSC_ADDR;
					next_r.bitn       = 4'h0;
					next_r.store_seen = 1'b0;
				end
			end
			DDSC_ADDR:
			begin
				if (pins.store)
					next_r.store_seen = 1'b1;
				if (sclk_rise)
				begin
					// Address enters LSB first
					next_r.sel  = {pins.sdi, r.sel[1]};
					next_r.bitn = r.bitn + 4'h1;
					if (r.bitn == 4'h1)
					begin
						next_r.st   = DDSC_DATA;
						next_r.bitn = 4'h0;
						// Held value is taken out of the register
						if (r.sel[1] && pins.sdi)
						begin
							next_r.is_second = 1'b1;
							next_r.shout     = r.d1.live;
						end
						else
						begin
							next_r.is_second = 1'b0;
							next_r.shout     = r.d0.live;
						end
						next_r.sdo = next_r.shout[0];
					end
				end
			end
			DDSC_DATA:
			begin
				if (pins.store)
					next_r.store_seen = 1'b1;
				if (sclk_rise)
				begin
					// Data LSB first in, held value LSB first out
					next_r.shin  = {pins.sdi, r.shin[7:1]};
					next_r.shout = {1'b0, r.shout[7:1]};
					next_r.sdo   = r.shout[1];
					next_r.bitn  = r.bitn + 4'h1;
					if (r.bitn == 4'h7)
					begin
						next_r.st  = DDSC_GAP;
						next_r.gap = 2'h0;
						// New value lands right after last data bit
						if (sel_ok)
						begin
							if (r.is_second)
								next_r.d1.live = next_r.shin;
							else
								next_r.d0.live = next_r.shin;
						end
					end
				end
			end
			DDSC_GAP:
			begin
				// Store window closes two clocks after last bit
				if (pins.store)
					next_r.store_seen = 1'b1;
				if (sclk_rise)
				begin
					next_r.gap = r.gap + 2'h1;
					if (r.gap == 2'(HOLD_CLKS - 1))
					begin
						next_r.st = DDSC_IDLE;
						if ((r.store_seen || pins.store) && sel_ok)
						begin
							next_r.st       = DDSC_BUSY;
							next_r.busy_cnt = 32'h0;
							// Busy only shows when supply is good
							next_r.rdy = !supply_ok;
						end
					end
				end
			end
			DDSC_BUSY:
			begin
				// Input ignored, output silent until done
				next_r.busy_cnt = r.busy_cnt + 32'h1;
				if (r.busy_cnt >= 32'(BUSY_CYCLES - 1))
				begin
					next_r.st  = DDSC_IDLE;
					next_r.rdy = 1'b1;
					// Program from the frame's own data, so a deselect
					// during the busy span cannot swap in the old value
					if (supply_ok)
					begin
						if (r.is_second)
							next_r.d1.nv = r.shin;
						else
							next_r.d0.nv = r.shin;
					end
				end
			end
			default:
				next_r.st = DDSC_IDLE;
		endcase

		// Output driver follows chip select, muted while busy
		next_r.oe = pins.cs && (next_r.st != DDSC_BUSY);

		// Deselect restores from nonvolatile copy; a store in
		// progress still completes since deselect leaves DDSC_BUSY in place.
		if (!pins.cs)
		begin
			next_r.d0.live = r.d0.nv;
			next_r.d1.live = r.d1.nv;
			next_r.sdo     = 1'b0;
			if (r.st != DDSC_BUSY)
				next_r.st = DDSC_IDLE;
		end

		next_r.out0 = next_r.d0.live;
		next_r.out1 = next_r.d1.live;
	end

	// ========================================================================
	// State register; reset acts as power-on restore, no serial clock
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			r       <= '0;
			r.st    <= DDSC_IDLE;
			r.d0    <= '{live: EEPROM_RST, nv: EEPROM_RST};
			r.d1    <= '{live: EEPROM_RST, nv: EEPROM_RST};
			r.out0  <= EEPROM_RST;
			r.out1  <= EEPROM_RST;
			r.rdy   <= 1'b1;
		end
		else
			r <= next_r;
	end

	assign serial_out         = r.sdo;
	assign serial_out_oe      = r.oe;
	assign store_ready_n_busy = r.rdy;
	assign first_dac_output   = r.out0;
	assign second_dac_output  = r.out1;

endmodule : ddsc_top
